// ---- shi_pkg.sv ----
// Overview of operation
// R1: chip enable high holds the serial logic in reset, dropping partial bytes.
// R2: a transfer runs from chip enable falling to chip enable rising.
// R3: serial data input is sampled on each rising serial clock edge.
// R4: every link unit is an eight-bit byte, most significant bit first.
// R5: the host sends the subaddress byte first after chip enable falls.
// R6: subaddress bit 7 gives direction: 0 write, 1 read.
// R7: only subaddress bits 6 to 5 equal to 01 take part; bits 4-0 ignored.
// R8: the subaddress match lets several devices share one bus.
// R9: in a write, the byte after the subaddress is a control byte.
// R10: RAM data and commands may mix in one access, or come alone.
// R11: the host deasserts chip enable between accesses, never holds it low.
// R12: don't-care bits are ignored whatever value the host drives.
// R13: memory writes: set pointer by command, then RAM data bytes follow.
// R14: memory reads: write access selecting RAM, then read access returns bytes.
// R15: an I2C master acknowledges every read byte and ends with stop.
// R16: the entry mode can make the address pointer step downward.
// R17: control byte: continuation bit and register-select field steer next bytes.
// R18: on I2C only the address matching the select pin level is acknowledged.
// R19: a read access drives requested bytes MSB first; output idle when deselected.
// R20: each data byte written or read steps the pointer by one.
package shi_pkg;
    localparam int BYTE_BITS = 8;
    localparam int DIR_BIT = 7;
    localparam int SA_HI = 6;
    localparam int SA_LO = 5;
    localparam logic [1:0] SA_MATCH = 2'h1;
    localparam int CO_BIT = 7;
    localparam int RS_HI = 6;
    localparam int RS_LO = 5;
    localparam logic [1:0] RS_RAM = 2'h1;
    localparam int SET_ADDR_BIT = 7;
    localparam int ADDR_W = 7;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam int SYNC_STAGES = 2;
    localparam int BUF_DEPTH = 2;
    localparam int WR_W = 1 + ADDR_W + BYTE_BITS;

    typedef enum logic [2:0] {
        SHI_SUB = 3'h0,
        SHI_CTRL = 3'h1,
        SHI_DATA = 3'h2,
        SHI_READ = 3'h3,
        SHI_SKIP = 3'h4
    } shi_state_type;
endpackage : shi_pkg

// ---- shi_buffer.sv ----
`timescale 1ns/1ps
module shi_buffer #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] store [0:1];
    logic wr_idx;
    logic rd_idx;
    logic [1:0] count;
    logic push;
    logic pop;

    // two entries so that one stalled word does not block the next
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = store[rd_idx];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // entry storage
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            store[0] <= '0;
            store[1] <= '0;
        end else if (push) begin
            store[wr_idx] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_idx <= ~wr_idx;
            end
            if (pop) begin
                rd_idx <= ~rd_idx;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule : shi_buffer

// ---- shi_serial_host.sv ----
`timescale 1ns/1ps
module shi_serial_host (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // serial link pins
    input wire logic sclk,
    input wire logic ce_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_en,
    // entry mode from the command decoder
    input wire logic addr_decrement,
    // write stream toward memory and command logic
    output logic wr_valid,
    input wire logic wr_ready,
    output logic wr_is_ram,
    output logic [shi_pkg::ADDR_W-1:0] wr_addr,
    output logic [shi_pkg::BYTE_BITS-1:0] wr_data,
    // memory read port, data due one cycle after the request
    output logic rd_req,
    output logic [shi_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [shi_pkg::BYTE_BITS-1:0] rd_data,
    // status
    output logic overrun
);
    import shi_pkg::*;

    logic [SYNC_STAGES:0] sclk_sync;
    logic [SYNC_STAGES-1:0] ce_sync;
    logic [SYNC_STAGES-1:0] sdi_sync;
    logic frame_off;
    logic rise;
    logic fall;
    logic [2:0] bit_cnt;
    logic [6:0] rx_shift;
    logic byte_done;
    logic [BYTE_BITS-1:0] rx_byte;
    logic sa_match;
    shi_state_type state;
    logic ctrl_co;
    logic [1:0] ctrl_rs;
    logic push;
    logic push_ok;
    logic push_ram;
    logic in_ready;
    logic [ADDR_W-1:0] pointer;
    logic load_pend;
    logic [BYTE_BITS-1:0] tx_shift;

    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic down);
        step_addr = down ? a - 7'h01 : a + 7'h01;
    endfunction : step_addr

    // pins cross into mclk; the second stage is looked at, and for the clock also the third, for edge detection
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync <= '0;
            ce_sync <= '1;
            sdi_sync <= '0;
        end else begin
            sclk_sync <= {sclk_sync[SYNC_STAGES-1:0], sclk};
            ce_sync <= {ce_sync[0], ce_n};
            sdi_sync <= {sdi_sync[0], serial_data_in};
        end
    end

    assign frame_off = ce_sync[1]; // R1 R2
    assign rise = sclk_sync[1] && !sclk_sync[2];
    assign fall = !sclk_sync[1] && sclk_sync[2];

    // bit counter and input shifter; data and clock share the same delay
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt <= 3'h0;
            rx_shift <= 7'h00;
        end else if (frame_off) begin
            bit_cnt <= 3'h0; // R1
            rx_shift <= 7'h00;
        end else if (rise) begin
            bit_cnt <= bit_cnt + 3'h1; // R3
            rx_shift <= {rx_shift[5:0], sdi_sync[1]}; // R4
        end
    end

    assign byte_done = rise && !frame_off && (bit_cnt == 3'h7);
    assign rx_byte = {rx_shift, sdi_sync[1]}; // R4
    assign sa_match = (rx_byte[SA_HI:SA_LO] == SA_MATCH); // R7 R8 R12

    // access sequencing; the first byte of each frame is the subaddress
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SHI_SUB;
            ctrl_co <= 1'b0;
            ctrl_rs <= 2'h0;
        end else if (frame_off) begin
            state <= SHI_SUB; // R1 R11
            ctrl_co <= 1'b0;
            ctrl_rs <= 2'h0;
        end else if (byte_done) begin
            unique case (state)
                SHI_SUB: begin
                    if (!sa_match) begin
                        state <= SHI_SKIP; // R7 R8
                    end else if (rx_byte[DIR_BIT]) begin
                        state <= SHI_READ; // R6 R14
                    end else begin
                        state <= SHI_CTRL; // R5 R6 R9
                    end
                end
                SHI_CTRL: begin
                    ctrl_co <= rx_byte[CO_BIT]; // R17
                    ctrl_rs <= rx_byte[RS_HI:RS_LO]; // R17 R12
                    state <= SHI_DATA;
                end
                SHI_DATA: begin
                    // a set continuation bit brings another control byte
                    state <= ctrl_co ? SHI_CTRL : SHI_DATA; // R10 R17
                end
                SHI_READ: begin
                    state <= SHI_READ;
                end
                SHI_SKIP: begin
                    state <= SHI_SKIP; // R7
                end
                default: begin
                    state <= SHI_SUB;
                end
            endcase
        end
    end

    assign push = byte_done && (state == SHI_DATA);
    assign push_ok = push && in_ready;
    assign push_ram = (ctrl_rs == RS_RAM); // R17

    // the host cannot be stalled, so a full buffer is reported, not hidden
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            overrun <= 1'b0;
        end else if (push && !in_ready) begin
            overrun <= 1'b1;
        end else if (frame_off) begin
            overrun <= 1'b0;
        end
    end

    // address pointer: loaded by the set-address command, stepped per RAM byte written or read
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pointer <= ADDR_RESET;
        end else if (push_ok && !push_ram && rx_byte[SET_ADDR_BIT] && (ctrl_rs == 2'h0)) begin
            pointer <= rx_byte[ADDR_W-1:0]; // R13
        end else if ((push_ok && push_ram) || rd_req) begin
            pointer <= step_addr(pointer, addr_decrement); // R16 R20
        end
    end

    // every read byte boundary fetches the next byte, one ahead of the clock
    assign rd_req = byte_done && (((state == SHI_SUB) && sa_match && rx_byte[DIR_BIT]) || (state == SHI_READ)); // R14
    assign rd_addr = pointer;

    // output shifter, changed on falling edges so the host samples on rising
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            load_pend <= 1'b0;
            tx_shift <= 8'h00;
            serial_data_out <= 1'b0;
            serial_data_out_en <= 1'b0;
        end else if (frame_off) begin
            load_pend <= 1'b0;
            tx_shift <= 8'h00;
            serial_data_out <= 1'b0; // R19
            serial_data_out_en <= 1'b0; // R19
        end else begin
            load_pend <= rd_req;
            serial_data_out_en <= (state == SHI_READ); // R19
            if (load_pend) begin
                tx_shift <= rd_data; // R19
            end else if (fall && (state == SHI_READ)) begin
                tx_shift <= {tx_shift[6:0], 1'b0}; // R4
            end
            if (fall && (state == SHI_READ)) begin
                serial_data_out <= tx_shift[BYTE_BITS-1]; // R4 R19
            end
        end
    end

    shi_buffer #(
        .WIDTH(WR_W)
    ) u_buffer (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(push),
        .in_ready(in_ready),
        .in_data({push_ram, pointer, rx_byte}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data({wr_is_ram, wr_addr, wr_data})
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_frame_reset_state: assert property (frame_off |=> (state == SHI_SUB) && (bit_cnt == 3'h0)) // R1
        else $error("state not reset while deselected");
    a_frame_sdo_idle: assert property (frame_off |=> !serial_data_out_en && !serial_data_out) // R19
        else $error("data output active while deselected");
    a_sample_rise: assert property ((rise && !frame_off) |=> rx_shift[0] == $past(sdi_sync[1])) // R3
        else $error("input not sampled on rising edge");
    a_dir_read: assert property ((state == SHI_SUB && byte_done && sa_match && rx_byte[DIR_BIT]) // R6
        |=> state == SHI_READ)
        else $error("read direction not taken");
    a_dir_write: assert property ((state == SHI_SUB && byte_done && sa_match && !rx_byte[DIR_BIT]) // R9
        |=> state == SHI_CTRL)
        else $error("write access did not expect control byte");
    a_sa_mismatch: assert property ((state == SHI_SUB && byte_done && !sa_match) |=> state == SHI_SKIP) // R7
        else $error("foreign subaddress not ignored");
    a_skip_quiet: assert property ((state == SHI_SKIP) |-> !push && !rd_req && !serial_data_out_en) // R8
        else $error("ignored access produced activity");
    a_ctrl_fields: assert property ((state == SHI_CTRL && byte_done) // R17
        |=> ctrl_co == $past(rx_byte[CO_BIT]) && ctrl_rs == $past(rx_byte[RS_HI:RS_LO]))
        else $error("control byte fields not captured");
    a_ptr_step: assert property ((push_ok && push_ram) |=> pointer == $past(step_addr(pointer, addr_decrement))) // R20
        else $error("pointer did not step after RAM byte");
    a_tx_load: assert property ((rd_req ##1 !frame_off) |=> tx_shift == $past(rd_data)) // R14
        else $error("read byte not loaded");
    a_sdo_msb: assert property ((fall && state == SHI_READ && !frame_off && !load_pend) // R4
        |=> serial_data_out == $past(tx_shift[7]))
        else $error("output bit not msb first");
endmodule : shi_serial_host

// ---- shi_host_model.sv ----
`timescale 1ns/1ps
// bus master on the far side of the link; paced by the system clock, acting at its falling edge
module shi_host_model (
    // pacing clock
    input wire logic mclk,
    // link pins
    output logic sclk,
    output logic ce_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    localparam int HALF = 16; // 80 ns, half of the 160 ns link period

    // link idles with clock low and chip enable high
    initial begin
        sclk = 1'b0;
        ce_n = 1'b1;
        serial_data_in = 1'b0;
    end

    task half_wait;
        repeat (HALF) @(negedge mclk);
    endtask : half_wait

    // chip enable low opens the transfer
    task begin_frame;
        @(negedge mclk);
        ce_n = 1'b0;
        half_wait;
    endtask : begin_frame

    // released data line flips so a stale level is never mistaken for data
    task end_frame;
        half_wait;
        ce_n = 1'b1;
        serial_data_in = ~serial_data_in;
        half_wait;
        half_wait;
    endtask : end_frame

    // data changes while clock is low, read data taken at the rising edge
    task put_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        for (i = 0; i < n; i++) begin
            serial_data_in = tx[7-i];
            half_wait;
            sclk = 1'b1;
            rx = {rx[6:0], serial_data_out};
            half_wait;
            sclk = 1'b0;
        end
    endtask : put_bits
endmodule : shi_host_model

// ---- serial_host_interface_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module serial_host_interface_tb;
    import shi_pkg::*;
    typedef struct {logic [7:0] sub; logic [7:0] ctrl; logic [7:0] data; logic taken;} shi_row_type;
    logic mclk, reset_n, sclk, ce_n, serial_data_in, serial_data_out, serial_data_out_en;
    logic addr_decrement, wr_valid, wr_ready, wr_is_ram, rd_req, overrun;
    logic [ADDR_W-1:0] wr_addr, rd_addr, ptr;
    logic [BYTE_BITS-1:0] wr_data, rd_data, r;
    logic [WR_W-1:0] got[$], exp_q[$];
    shi_row_type rows[8];
    int n_errors, n_checks, i;

    shi_serial_host dut (.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .ce_n(ce_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_out_en(serial_data_out_en), .addr_decrement(addr_decrement),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_is_ram(wr_is_ram), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .overrun(overrun));
    shi_host_model host (.mclk(mclk), .sclk(sclk), .ce_n(ce_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out));

    // clock, 5 ns period
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // memory answers a request by the next cycle; contents derive from the address
    always @(negedge mclk) if (rd_req === 1'b1) rd_data <= {rd_addr[0], rd_addr};
    // consumer collects every accepted word
    always @(posedge mclk) if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back({wr_is_ram, wr_addr, wr_data});

    task summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    // subaddress leads every frame
    task frame(input logic [7:0] b[$]);
        int k;
        host.begin_frame;
        for (k = 0; k < b.size(); k++) host.put_bits(b[k], 8, r);
        host.end_frame;
    endtask : frame

    // predicted word; pointer commands move the model pointer too
    task expect_word(input logic [1:0] sel, input logic [7:0] d);
        if (sel == RS_RAM) begin
            exp_q.push_back({1'b1, ptr, d});
            ptr = addr_decrement ? ptr - 1'b1 : ptr + 1'b1;
        end else begin
            exp_q.push_back({1'b0, {ADDR_W{1'b0}}, d});
            if (d[SET_ADDR_BIT] && sel == 2'h0) ptr = d[ADDR_W-1:0];
        end
    endtask : expect_word

    // address field is only meaningful on memory words, so commands compare without it
    task drain_check;
        int k;
        logic [WR_W-1:0] g, e;
        for (k = 0; k < 400 && got.size() < exp_q.size(); k++) @(negedge mclk);
        if (got.size() != exp_q.size()) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got.size(), exp_q.size());
            summarize;
        end
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            g = got.pop_front();
            if (!e[WR_W-1]) g[WR_W-2:BYTE_BITS] = '0;
            `CHK(g, e)
        end
        repeat (20) @(negedge mclk);
        `CHK(got.size(), 0)
        `CHK(wr_valid, 1'b0)
    endtask : drain_check

    // read frame; one byte is prefetched past the last one clocked out
    task read_bytes(input logic [7:0] sub, input int n, input logic on);
        int k;
        host.begin_frame;
        host.put_bits(sub, 8, r);
        for (k = 0; k < n; k++) begin
            host.put_bits(8'h00, 8, r);
            `CHK(serial_data_out_en, on)
            if (on) `CHK(r, {ptr[0], ptr})
            ptr = addr_decrement ? ptr - 1'b1 : ptr + 1'b1;
        end
        host.end_frame;
        `CHK(serial_data_out_en, 1'b0)
        `CHK(serial_data_out, 1'b0)
        if (on) ptr = addr_decrement ? ptr - 1'b1 : ptr + 1'b1;
    endtask : read_bytes

    initial begin
        reset_n = 1'b0;
        wr_ready = 1'b1;
        addr_decrement = 1'b0;
        rd_data = 8'h00;
        n_errors = 0;
        n_checks = 0;
        ptr = ADDR_RESET;
        rows = '{'{8'h20, 8'h40, 8'ha5, 1'b1}, '{8'h3f, 8'h00, 8'h8a, 1'b1}, '{8'h00, 8'h40, 8'h11, 1'b0},
            '{8'h60, 8'h40, 8'h22, 1'b0}, '{8'h40, 8'h40, 8'h33, 1'b0}, '{8'h20, 8'h60, 8'h28, 1'b1},
            '{8'h2f, 8'h3f, 8'h9c, 1'b1}, '{8'h20, 8'h5f, 8'h00, 1'b1}};
        repeat (4) @(negedge mclk);
        `CHK({wr_valid, overrun, serial_data_out_en}, 3'h0)
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        // ordinary frames: one control byte, one data byte
        for (i = 0; i < 8; i++) begin
            frame('{rows[i].sub, rows[i].ctrl, rows[i].data});
            if (rows[i].taken) expect_word(rows[i].ctrl[6:5], rows[i].data);
            drain_check;
        end
        // continuation bit: command, then a fresh control byte, then memory data
        frame('{8'h20, 8'h80, 8'h85, 8'h20, 8'hc3, 8'h3c});
        expect_word(2'h0, 8'h85);
        expect_word(2'h1, 8'hc3);
        expect_word(2'h1, 8'h3c);
        drain_check;
        // half a byte then chip enable high: the fragment must vanish
        host.begin_frame;
        host.put_bits(8'h40, 4, r);
        host.end_frame;
        frame('{8'h20, 8'h20, 8'h5a});
        expect_word(2'h1, 8'h5a);
        drain_check;
        // stalled consumer: two words kept, the rest refused and flagged
        wr_ready = 1'b0;
        host.begin_frame;
        // subaddress, memory control byte, then four data bytes into a two-entry buffer
        for (i = 0; i < 6; i++) host.put_bits((i < 2) ? 8'h20 : 8'h70 + 8'(i), 8, r);
        `CHK(overrun, 1'b1)
        `CHK(wr_valid, 1'b1)
        host.end_frame;
        `CHK(overrun, 1'b0)
        expect_word(2'h1, 8'h72);
        expect_word(2'h1, 8'h73);
        wr_ready = 1'b1;
        drain_check;
        // read upward from address 07
        frame('{8'h20, 8'h00, 8'h87});
        expect_word(2'h0, 8'h87);
        drain_check;
        frame('{8'h20, 8'h20});
        read_bytes(8'ha0, 3, 1'b1);
        // read downward from address 4f
        addr_decrement = 1'b1;
        frame('{8'h20, 8'h00, 8'hcf});
        expect_word(2'h0, 8'hcf);
        drain_check;
        read_bytes(8'hbf, 2, 1'b1);
        addr_decrement = 1'b0;
        // read aimed at another subaddress stays silent
        read_bytes(8'he0, 1, 1'b0);
        summarize;
    end
endmodule : serial_host_interface_tb
